// >>> sfid_consts.svh
// Constants of the serial flash instruction front end: opcodes,
// status bit positions, protection geometry and byte counts.
// Definitions only; included by the protect and decoder modules and the bench.
`ifndef SFID_CONSTS_SVH
`define SFID_CONSTS_SVH

// Instruction opcodes
`define SFID_OP_WREN 8'h06
`define SFID_OP_WRDI 8'h04
`define SFID_OP_RDSR 8'h05
`define SFID_OP_WRSR 8'h01
`define SFID_OP_READ 8'h03
`define SFID_OP_FAST 8'h0B
`define SFID_OP_DUAL 8'h3B
`define SFID_OP_PROG 8'h02
`define SFID_OP_SE4K 8'h20
`define SFID_OP_BE32 8'h52
`define SFID_OP_BE64 8'hD8
`define SFID_OP_CE_A 8'hC7
`define SFID_OP_CE_B 8'h60
`define SFID_OP_PDWN 8'hB9
`define SFID_OP_RPID 8'hAB
`define SFID_OP_MFID 8'h90
`define SFID_OP_JDID 8'h9F

// Status byte layout
`define SFID_SR_BUSY 0
`define SFID_SR_WEL 1
`define SFID_SR_BP_LO 2
`define SFID_SR_BP_HI 4
`define SFID_SR_TB 5
`define SFID_SR_SRP 7
`define SFID_SR_WMASK 8'hBC

// Protection geometry, 25 bits so the array end fits
`define SFID_PROT_UNIT 25'h002_0000
`define SFID_ADDR_END 25'h080_0000
`define SFID_BP_NONE 3'h0
`define SFID_BP_ALL 3'h7

// Byte and bit counts of the instruction phases
`define SFID_ADDR_BYTES 2'h3
`define SFID_FAST_DUMMY 2'h1
`define SFID_ID_DUMMY 2'h3
`define SFID_PAGE_MAX 9'h100
`define SFID_BITS_SINGLE 3'h7
`define SFID_BITS_DUAL 3'h3

`endif

// >>> sfid_pkg.sv
// Types shared by the instruction front end modules.
// Uses no constants from sfid_consts.svh.
package sfid_pkg;

  // Phase of the current chip-select period
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_DIN,
    ST_DOUT,
    ST_HOLD,
    ST_IGNORE
  } sfid_state_t;

endpackage

// >>> sfid_sync.sv
// Two-flop synchroniser for the serial link pins.
// Inputs are asynchronous to clk_sys; outputs are safe to use.
`timescale 1ns/10ps
module sfid_sync
#(
  parameter logic [2:0] RST_VAL = 3'h0
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pin levels in and out
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_sync
);

  logic [2:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= RST_VAL;
      pin_sync <= RST_VAL;
    end
    else
    begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end

endmodule

// >>> sfid_protect.sv
// Protected-range decode from the top/bottom and size bits.
// Purely combinational; the address is held stable by the caller.
`timescale 1ns/10ps
`include "sfid_consts.svh"
module sfid_protect
(
  // Protection settings
  input wire logic top_bottom_select,
  input wire logic [2:0] protect_size,
  // Address under test
  input wire logic [23:0] addr,
  output logic prot_hit
);

  logic [24:0] span;

  // Span doubles with each code, from one unit at code 1
  assign span = `SFID_PROT_UNIT << (protect_size - 3'h1);

  always_comb
  begin
    // RL1 none or all
    if (protect_size == `SFID_BP_NONE)
      prot_hit = 1'b0;
    else if (protect_size == `SFID_BP_ALL)
      prot_hit = 1'b1;
    // RL3 bottom region
    else if (top_bottom_select)
      prot_hit = {1'b0, addr} < span;
    // RL2 top region
    else
      prot_hit = {1'b0, addr} >= (`SFID_ADDR_END - span);
  end

endmodule

// >>> sfid_decoder.sv
// Instruction front end of a serial flash: frames opcodes, collects
// address, dummy and data bytes, returns status and identity bytes.
// Assumes an array engine on clk_sys that reports busy and gives read
// data one cycle after rd_addr changes.
`timescale 1ns/10ps
`include "sfid_consts.svh"
// What this block does
// RL1: size code zero protects nothing; code seven protects the whole array.
// RL2: top select zero protects upper 1/64 to 1/2, ending at top.
// RL3: top select one protects lower 128KB doubling up to 4MB from zero.
// RL4: first byte after chip select falls is the opcode.
// RL5: input bits taken on rising serial clock, MSB first.
// RL6: chip select rising ends an instruction; reads may end anywhere.
// RL7: write-type instruction with a partial last byte is dropped.
// RL8: while busy, every instruction except status read is ignored.
// RL9: decode seventeen opcodes, including enable, disable, status read, write.
// RL10: address instructions take three address bytes, high first.
// RL11: page program takes up to 256 bytes; erases cover their sizes.
// RL12: fast reads add one dummy byte; dual read splits bits over lines.
// RL13: returned bytes leave on data-out, MSB first.
// RL14: status read repeats the status byte until chip select rises.
// RL15: release opcode leaves power-down and repeats device id after dummies.
// RL16: identity reads return maker, device, type and capacity bytes.
// RL17: protect bits sit at status bits 4..2 and reset to zero.
// RL18: program and erase into the protected region are refused.
// RL19: status bit 0 shows busy during program, erase, status write.
// RL20: data-out driven only while returning bytes, released otherwise.
// RL21: unknown opcodes are ignored until chip select rises.
module sfid_decoder
  import sfid_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'hA5,  // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h3C,  // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h21   // Arbitrary value
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Serial link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_in_out_line_i,
  output logic data_in_out_line_o,
  output logic data_in_out_line_oe,
  output logic data_out_o,
  output logic data_out_oe,
  // Array engine side
  input wire logic array_busy,
  input wire logic [7:0] rd_data,
  output logic [23:0] rd_addr,
  output logic cmd_valid,
  output logic [7:0] cmd_op,
  output logic [23:0] cmd_addr,
  output logic pgm_valid,
  output logic [7:0] pgm_data,
  // Status view
  output logic [7:0] status,
  output logic powered_down
);

  logic sclk_s;
  logic cs_s;
  logic dio_s;
  logic sclk_q;
  logic cs_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [2:0] bit_cnt;
  logic [6:0] sh_in;
  logic [7:0] byte_in;
  logic byte_done;
  sfid_state_t state_reg;
  logic [7:0] op_reg;
  logic [23:0] addr_reg;
  logic [1:0] left_reg;
  logic [8:0] page_cnt;
  logic [7:0] sr_new;
  logic wel_reg;
  logic top_bottom_select;
  logic protect_size_bit2;
  logic protect_size_bit1;
  logic protect_size_bit0;
  logic srp_reg;
  logic prot_hit;
  logic commit_ok;
  logic refuse;
  logic out_load;
  logic [7:0] out_byte;
  logic [7:0] out_sh;
  logic [2:0] out_cnt;
  logic [1:0] out_idx;
  logic dual;

  // Program and erase opcodes that need the write latch
  function automatic logic is_array_op(input logic [7:0] op);
    case (op)
      `SFID_OP_PROG, `SFID_OP_SE4K, `SFID_OP_BE32, `SFID_OP_BE64,
      `SFID_OP_CE_A, `SFID_OP_CE_B: is_array_op = 1'b1;
      default: is_array_op = 1'b0;
    endcase
  endfunction

  // Opcodes whose data phase reads the array
  function automatic logic is_read_op(input logic [7:0] op);
    is_read_op = (op == `SFID_OP_READ) || (op == `SFID_OP_FAST) || (op == `SFID_OP_DUAL);
  endfunction

  // Pins pass two flops; chip select idles high
  sfid_sync #(
    .RST_VAL(3'h2)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({sclk, cs_n, data_in_out_line_i}),
    .pin_sync({sclk_s, cs_s, dio_s})
  );

  sfid_protect u_protect (
    .top_bottom_select(top_bottom_select),
    .protect_size({protect_size_bit2, protect_size_bit1, protect_size_bit0}),
    .addr(addr_reg),
    .prot_hit(prot_hit)
  );

  // Edge detection on the synchronised link levels
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_s;
      cs_q <= cs_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_q & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_q & ~cs_s;
  assign cs_fall = ~cs_s & cs_q;
  assign cs_rise = cs_s & ~cs_q;
  assign byte_in = {sh_in, dio_s};
  assign byte_done = sclk_rise && (bit_cnt == 3'h7);

  // RL5 rising edge capture
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt <= 3'h0;
      sh_in <= 7'h00;
    end
    else if (cs_fall)
      bit_cnt <= 3'h0;
    else if (sclk_rise)
    begin
      bit_cnt <= bit_cnt + 3'h1;
      sh_in <= byte_in[6:0];
    end
  end

  // Instruction sequencing over one chip-select period
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      op_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
      left_reg <= 2'h0;
      page_cnt <= 9'h000;
      sr_new <= 8'h00;
    end
    // RL6 chip select ends
    else if (cs_s)
      state_reg <= ST_IDLE;
    // RL4 opcode comes first
    else if (cs_fall)
    begin
      state_reg <= ST_OPCODE;
      page_cnt <= 9'h000;
    end
    else if (byte_done)
    begin
      unique case (state_reg)
        ST_IDLE, ST_DOUT, ST_HOLD, ST_IGNORE:
          state_reg <= state_reg;
        ST_OPCODE:
        begin
          op_reg <= byte_in;
          // RL8 busy ignores
          if ((array_busy && byte_in != `SFID_OP_RDSR) || (powered_down && byte_in != `SFID_OP_RPID))
            state_reg <= ST_IGNORE;
          else
          begin
            // RL9 opcode decode
            case (byte_in)
              `SFID_OP_RDSR, `SFID_OP_JDID: state_reg <= ST_DOUT;
              `SFID_OP_WRSR: state_reg <= ST_DIN;
              `SFID_OP_WREN, `SFID_OP_WRDI, `SFID_OP_PDWN,
              `SFID_OP_CE_A, `SFID_OP_CE_B: state_reg <= ST_HOLD;
              // RL10 three address bytes
              `SFID_OP_READ, `SFID_OP_FAST, `SFID_OP_DUAL, `SFID_OP_PROG,
              `SFID_OP_SE4K, `SFID_OP_BE32, `SFID_OP_BE64:
              begin
                state_reg <= ST_ADDR;
                left_reg <= `SFID_ADDR_BYTES;
              end
              `SFID_OP_RPID, `SFID_OP_MFID:
              begin
                state_reg <= ST_DUMMY;
                left_reg <= `SFID_ID_DUMMY;
              end
              // RL21 unknown ignored
              default: state_reg <= ST_IGNORE;
            endcase
          end
        end
        ST_ADDR:
        begin
          // RL10 high byte first
          addr_reg <= {addr_reg[15:0], byte_in};
          left_reg <= left_reg - 2'h1;
          if (left_reg == 2'h1)
          begin
            if (op_reg == `SFID_OP_READ)
              state_reg <= ST_DOUT;
            else if (op_reg == `SFID_OP_PROG)
              state_reg <= ST_DIN;
            // RL12 one dummy byte
            else if (is_read_op(op_reg))
            begin
              state_reg <= ST_DUMMY;
              left_reg <= `SFID_FAST_DUMMY;
            end
            else
              state_reg <= ST_HOLD;
          end
        end
        ST_DUMMY:
        begin
          left_reg <= left_reg - 2'h1;
          if (left_reg == 2'h1)
            state_reg <= ST_DOUT;
        end
        ST_DIN:
        begin
          // RL11 page data limit
          if (op_reg == `SFID_OP_PROG)
          begin
            if (page_cnt != `SFID_PAGE_MAX)
              page_cnt <= page_cnt + 9'h001;
          end
          else
          begin
            sr_new <= byte_in;
            state_reg <= ST_HOLD;
          end
        end
      endcase
    end
  end

  // RL7 whole bytes only
  assign commit_ok = cs_rise && (bit_cnt == 3'h0) &&
    ((state_reg == ST_HOLD) || (state_reg == ST_DIN && op_reg == `SFID_OP_PROG && page_cnt != 9'h000));

  // RL18 protected region refusal
  assign refuse = is_array_op(op_reg) && (prot_hit ||
    ((op_reg == `SFID_OP_CE_A || op_reg == `SFID_OP_CE_B) && status[`SFID_SR_BP_HI:`SFID_SR_BP_LO] != `SFID_BP_NONE));

  // Write latch, protect bits and power-down entry updated at instruction end; power-down release after the opcode byte
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wel_reg <= 1'b0;
      srp_reg <= 1'b0;
      // RL17 protect bits default
      top_bottom_select <= 1'b0;
      protect_size_bit2 <= 1'b0;
      protect_size_bit1 <= 1'b0;
      protect_size_bit0 <= 1'b0;
      powered_down <= 1'b0;
    end
    // RL15 release power-down
    else if (byte_done && state_reg == ST_OPCODE && byte_in == `SFID_OP_RPID && !array_busy)
      powered_down <= 1'b0;
    else if (commit_ok)
    begin
      case (op_reg)
        `SFID_OP_WREN: wel_reg <= 1'b1;
        `SFID_OP_WRDI: wel_reg <= 1'b0;
        `SFID_OP_PDWN: powered_down <= 1'b1;
        `SFID_OP_WRSR:
        begin
          if (wel_reg)
          begin
            wel_reg <= 1'b0;
            srp_reg <= sr_new[`SFID_SR_SRP];
            top_bottom_select <= sr_new[`SFID_SR_TB];
            {protect_size_bit2, protect_size_bit1, protect_size_bit0} <= sr_new[`SFID_SR_BP_HI:`SFID_SR_BP_LO];
          end
        end
        default:
        begin
          if (wel_reg && !refuse)
            wel_reg <= 1'b0;
        end
      endcase
    end
  end

  // Command hand-off to the array engine, one pulse per accepted program, erase or status write
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmd_valid <= 1'b0;
      cmd_op <= 8'h00;
      cmd_addr <= 24'h00_0000;
    end
    else
    begin
      // RL11 erase and program commands
      cmd_valid <= commit_ok && wel_reg && (op_reg == `SFID_OP_WRSR || (is_array_op(op_reg) && !refuse));
      if (commit_ok)
      begin
        cmd_op <= op_reg;
        cmd_addr <= addr_reg;
      end
    end
  end

  // Page data stream; the engine keeps it only if a command follows
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pgm_valid <= 1'b0;
      pgm_data <= 8'h00;
    end
    else
    begin
      pgm_valid <= byte_done && state_reg == ST_DIN && op_reg == `SFID_OP_PROG &&
        page_cnt != `SFID_PAGE_MAX && wel_reg && !prot_hit;
      if (byte_done)
        pgm_data <= byte_in;
    end
  end

  // RL19 busy in bit zero
  assign status = {srp_reg, 1'b0, top_bottom_select, protect_size_bit2, protect_size_bit1,
    protect_size_bit0, wel_reg, array_busy};

  assign dual = (op_reg == `SFID_OP_DUAL);
  assign out_load = (state_reg == ST_DOUT) && sclk_fall && (out_cnt == 3'h0);

  // Next byte to return
  always_comb
  begin
    // RL14 status repeats
    case (op_reg)
      `SFID_OP_RDSR: out_byte = status;
      // RL15 device id repeats
      `SFID_OP_RPID: out_byte = DEVICE_ID;
      // RL16 identity bytes
      `SFID_OP_MFID: out_byte = (out_idx == 2'h0) ? MAKER_ID : DEVICE_ID;
      `SFID_OP_JDID: out_byte = (out_idx == 2'h0) ? MAKER_ID : ((out_idx == 2'h1) ? MEM_TYPE : CAPACITY);
      default: out_byte = rd_data;
    endcase
  end

  // Read address follows the data stream
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rd_addr <= 24'h00_0000;
    else if (byte_done && state_reg == ST_ADDR && left_reg == 2'h1)
      rd_addr <= {addr_reg[15:0], byte_in};
    else if (out_load && is_read_op(op_reg))
      rd_addr <= rd_addr + 24'h00_0001;
  end

  // Output shifter; a new bit leaves on each falling serial clock
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      out_sh <= 8'h00;
      out_cnt <= 3'h0;
      out_idx <= 2'h0;
      data_out_o <= 1'b0;
      data_out_oe <= 1'b0;
      data_in_out_line_o <= 1'b0;
      data_in_out_line_oe <= 1'b0;
    end
    // RL20 release when deselected
    else if (cs_s)
    begin
      out_cnt <= 3'h0;
      out_idx <= 2'h0;
      data_out_oe <= 1'b0;
      data_in_out_line_oe <= 1'b0;
    end
    // RL13 MSB first
    else if (out_load)
    begin
      data_out_o <= out_byte[7];
      data_out_oe <= 1'b1;
      // RL12 dual output split
      data_in_out_line_o <= out_byte[6];
      data_in_out_line_oe <= dual;
      out_sh <= dual ? (out_byte << 2) : (out_byte << 1);
      out_cnt <= dual ? `SFID_BITS_DUAL : `SFID_BITS_SINGLE;
      if ((op_reg == `SFID_OP_JDID && out_idx != 2'h2) || (op_reg == `SFID_OP_MFID && out_idx == 2'h0))
        out_idx <= out_idx + 2'h1;
      else
        out_idx <= 2'h0;
    end
    else if (state_reg == ST_DOUT && sclk_fall)
    begin
      data_out_o <= out_sh[7];
      data_in_out_line_o <= out_sh[6];
      out_sh <= dual ? (out_sh << 2) : (out_sh << 1);
      out_cnt <= out_cnt - 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_protect_none: assert property (status[`SFID_SR_BP_HI:`SFID_SR_BP_LO] == `SFID_BP_NONE |-> !prot_hit) // RL1
    else $error("protection active with size code zero");
  a_protect_all: assert property (status[`SFID_SR_BP_HI:`SFID_SR_BP_LO] == `SFID_BP_ALL |-> prot_hit) // RL1
    else $error("address unprotected with size code seven");
  a_protect_top: assert property (!top_bottom_select && status[`SFID_SR_BP_HI:`SFID_SR_BP_LO] == 3'h1 // RL2
    |-> prot_hit == ({1'b0, addr_reg} >= `SFID_ADDR_END - `SFID_PROT_UNIT))
    else $error("upper 1/64 region decoded wrongly");
  a_protect_bottom: assert property (top_bottom_select && status[`SFID_SR_BP_HI:`SFID_SR_BP_LO] == 3'h1 // RL3
    |-> prot_hit == ({1'b0, addr_reg} < `SFID_PROT_UNIT))
    else $error("lower 1/64 region decoded wrongly");
  a_opcode_first: assert property (cs_fall |=> state_reg == ST_OPCODE && bit_cnt == 3'h0) // RL4
    else $error("opcode phase not started at chip select fall");
  a_partial_abort: assert property (cs_rise && bit_cnt != 3'h0 |=> !cmd_valid) // RL7
    else $error("command issued after a partial byte");
  a_busy_ignore: assert property (byte_done && state_reg == ST_OPCODE && array_busy // RL8
    && byte_in != `SFID_OP_RDSR |=> state_reg == ST_IGNORE)
    else $error("instruction accepted while busy");
  a_unknown_op: assert property (byte_done && state_reg == ST_OPCODE && !array_busy && !powered_down // RL21
    && byte_in == 8'hFF |=> state_reg == ST_IGNORE)
    else $error("undefined opcode not ignored");
  a_out_release: assert property (cs_s && cs_q |-> !data_out_oe && !data_in_out_line_oe) // RL20
    else $error("output driven while deselected");
  a_dual_only: assert property ($rose(data_in_out_line_oe) |-> op_reg == `SFID_OP_DUAL) // RL12
    else $error("bidirectional line driven outside dual read");
  a_prog_protect: assert property (cmd_valid && is_array_op(cmd_op) |-> $past(refuse) == 1'b0) // RL18
    else $error("program or erase issued into protected region");

endmodule

// >>> sfid_host_model.sv
// Host side of the serial link: drives sclk, cs_n and the data line in mode 0.
// Assumes the bench resolves the shared data line and feeds it back on dio.
`timescale 1ns/10ps
module sfid_host_model
(
  // Pins driven by the host
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  // Pins driven by the device
  input wire logic miso,
  input wire logic data_in_out_line
);
  localparam time HALF = 24ns;

  // Idle link; clock stands low outside frames
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic start();
    cs_n = 1'b0;
    #HALF;
  endtask

  task automatic bit_io(input logic b, output logic r);
    mosi = b;
    #HALF;
    sclk = 1'b1;
    r = miso;
    #HALF;
    sclk = 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
  endtask

  // Partial byte, top bits only
  task automatic bits(input logic [7:0] tx, input int n);
    logic r;
    for (int i = 7; i > 7 - n; i--)
      bit_io(tx[i], r);
  endtask

  task automatic dual_rx(output logic [7:0] rx);
    for (int k = 3; k >= 0; k--)
    begin
      mosi = ~mosi; // Released line must not look steady
      #HALF;
      sclk = 1'b1;
      rx[2 * k + 1] = miso;
      rx[2 * k] = data_in_out_line;
      #HALF;
      sclk = 1'b0;
    end
  endtask

  task automatic stop();
    #HALF;
    cs_n = 1'b1;
    mosi = ~mosi; // Released line shows the inverse
    #(2 * HALF);
  endtask
endmodule

// >>> tb_sfid_decoder.sv
// Self-checking bench for the instruction front end.
// Assumes the host model above and a tiny array engine built here.
`timescale 1ns/10ps
`include "sfid_consts.svh"
module tb_sfid_decoder;
  logic clk_sys, rst, sclk, cs_n, host_dio, dio_line, dio_o, dio_oe, dout, dout_oe, miso_line;
  logic array_busy, hold_busy, cmd_valid, pgm_valid, powered_down;
  logic [7:0] rd_data, cmd_op, pgm_data, status, rx;
  logic [23:0] rd_addr, cmd_addr;
  logic [7:0] pgm_q[$];
  int errors, tests_run, ncmd, n0;

  // Shared data line resolved from both drivers
  assign dio_line = dio_oe ? dio_o : host_dio;
  // Released data-out shows the inverse of its last bit, so early sampling shows up
  assign miso_line = dout_oe ? dout : ~dout;

  sfid_decoder #(.MAKER_ID(8'hA5), .DEVICE_ID(8'h5A), .MEM_TYPE(8'h3C), .CAPACITY(8'h21)) dut_u
  (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n), .data_in_out_line_i(dio_line),
    .data_in_out_line_o(dio_o), .data_in_out_line_oe(dio_oe), .data_out_o(dout), .data_out_oe(dout_oe),
    .array_busy(array_busy), .rd_data(rd_data), .rd_addr(rd_addr), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .pgm_valid(pgm_valid), .pgm_data(pgm_data), .status(status),
    .powered_down(powered_down)
  );

  sfid_host_model host_u
  (
    .sclk(sclk), .cs_n(cs_n), .mosi(host_dio), .miso(miso_line), .data_in_out_line(dio_line)
  );

  // Array engine: one busy cycle per command, read data a cycle late
  always @(negedge clk_sys)
  begin
    array_busy <= hold_busy | (cmd_valid === 1'b1);
    rd_data <= rd_addr[7:0] ^ 8'h3C;
  end

  // Command and page byte monitor
  always @(posedge clk_sys)
  begin
    if (cmd_valid === 1'b1)
      ncmd <= ncmd + 1;
    if (pgm_valid === 1'b1)
      pgm_q.push_back(pgm_data);
  end

  // Clock generator
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("checks=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic op1(input logic [7:0] op);
    host_u.start();
    host_u.byte_io(op, rx);
    host_u.stop();
  endtask

  // Status read twice in one frame, then released line
  task automatic sr_chk(input logic [7:0] exp);
    host_u.start();
    host_u.byte_io(`SFID_OP_RDSR, rx);
    for (int i = 0; i < 2; i++)
    begin
      host_u.byte_io(8'h00, rx);
      chk(rx, exp);
    end
    host_u.stop();
    chk(dout_oe, 1'b0);
  endtask

  task automatic sr_wr(input logic [7:0] v);
    op1(`SFID_OP_WREN);
    host_u.start();
    host_u.byte_io(`SFID_OP_WRSR, rx);
    host_u.byte_io(v, rx);
    host_u.stop();
  endtask

  task automatic acmd(input logic [7:0] op, input logic [23:0] a);
    host_u.start();
    host_u.byte_io(op, rx);
    for (int i = 2; i >= 0; i--)
      host_u.byte_io(a[8 * i +: 8], rx);
  endtask

  task automatic erase(input logic [23:0] a, input logic acc);
    op1(`SFID_OP_WREN);
    n0 = ncmd;
    acmd(`SFID_OP_SE4K, a);
    host_u.stop();
    chk(ncmd - n0, acc);
  endtask

  task automatic t_basic();
    sr_chk(8'h00);
    op1(`SFID_OP_WREN);
    sr_chk(8'h02);
    op1(`SFID_OP_WRDI);
    sr_chk(8'h00);
    hold_busy = 1'b1;
    op1(`SFID_OP_WREN);
    sr_chk(8'h01);
    hold_busy = 1'b0;
    sr_chk(8'h00);
  endtask

  task automatic t_protect();
    logic [24:0] sz, hi, lo;
    for (int t = 0; t < 2; t++)
      for (int b = 0; b < 8; b++)
      begin
        sz = 25'h002_0000 << ((b == 7) ? 5 : ((b == 0) ? 0 : b - 1));
        hi = (t == 0) ? 25'h080_0000 - sz : sz - 25'h000_0001;
        lo = (t == 0) ? hi - 25'h000_0001 : sz;
        sr_wr({2'h0, t[0], b[2:0], 2'h0});
        sr_chk({2'h0, t[0], b[2:0], 2'h0});
        erase(hi[23:0], b == 0);
        erase(lo[23:0], b != 7);
      end
    // Chip erase refused under full protection (size code seven), accepted once clear
    op1(`SFID_OP_WREN);
    n0 = ncmd;
    op1(`SFID_OP_CE_A);
    chk(ncmd - n0, 0);
    sr_wr(8'h00);
    op1(`SFID_OP_WREN);
    n0 = ncmd;
    op1(`SFID_OP_CE_B);
    chk(ncmd - n0, 1);
    chk(cmd_op, `SFID_OP_CE_B);
  endtask

  task automatic t_partial();
    op1(`SFID_OP_WREN);
    n0 = ncmd;
    acmd(`SFID_OP_SE4K, 24'h00_1000);
    host_u.bits(8'hFF, 3);
    host_u.stop();
    chk(ncmd - n0, 0);
    sr_chk(8'h02);
    op1(`SFID_OP_WRDI);
  endtask

  task automatic t_program();
    op1(`SFID_OP_WREN);
    pgm_q.delete();
    n0 = ncmd;
    acmd(`SFID_OP_PROG, 24'h00_0100);
    for (int i = 1; i < 4; i++)
      host_u.byte_io(8'h11 * i, rx);
    host_u.stop();
    chk(pgm_q.size(), 3);
    for (int i = 0; i < 3; i++)
      chk(pgm_q[i], 8'h11 * (i + 1));
    chk(ncmd - n0, 1);
    chk({cmd_op, cmd_addr}, {`SFID_OP_PROG, 24'h00_0100});
    sr_chk(8'h00);
  endtask

  task automatic t_reads();
    logic [7:0] ops[3];
    ops = '{`SFID_OP_READ, `SFID_OP_FAST, `SFID_OP_DUAL};
    foreach (ops[k])
    begin
      acmd(ops[k], 24'h00_0010);
      if (k > 0)
        host_u.byte_io(8'h00, rx);
      for (int i = 0; i < 2; i++)
      begin
        if (k == 2)
          host_u.dual_rx(rx);
        else
          host_u.byte_io(8'h00, rx);
        chk(rx, (8'h10 + i) ^ 8'h3C);
      end
      host_u.bits(8'h00, 3);
      host_u.stop();
      chk({dout_oe, dio_oe}, 2'h0);
    end
  endtask

  task automatic t_ids();
    logic [7:0] jd[4];
    jd = '{8'hA5, 8'h3C, 8'h21, 8'hA5};
    host_u.start();
    host_u.byte_io(`SFID_OP_JDID, rx);
    foreach (jd[i])
    begin
      host_u.byte_io(8'h00, rx);
      chk(rx, jd[i]);
    end
    host_u.stop();
    acmd(`SFID_OP_MFID, 24'h00_0000);
    host_u.byte_io(8'h00, rx);
    chk(rx, 8'hA5);
    host_u.byte_io(8'h00, rx);
    chk(rx, 8'h5A);
    host_u.stop();
    op1(`SFID_OP_PDWN);
    chk(powered_down, 1'b1);
    acmd(`SFID_OP_RPID, 24'h00_0000);
    for (int i = 0; i < 2; i++)
    begin
      host_u.byte_io(8'h00, rx);
      chk(rx, 8'h5A);
    end
    host_u.stop();
    chk(powered_down, 1'b0);
    acmd(8'hFF, 24'h00_0000);
    chk(dout_oe, 1'b0);
    host_u.stop();
    sr_chk(8'h00);
  endtask

  // Watchdog, well beyond the expected run of about 145 us
  initial
  begin
    #250us;
    errors++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    hold_busy = 1'b0;
    errors = 0;
    tests_run = 0;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_basic();
    t_protect();
    t_partial();
    t_program();
    t_reads();
    t_ids();
    stop_test();
  end
endmodule
